// *** rtl/qpg_pkg.sv ***
// Purpose: Shared constants for the programmable quadrature output block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses on the APB.
package qpg_pkg;
    // Register byte offsets.
    localparam logic [7:0] QPG_OFS_CTRL = 8'h00;
    localparam logic [7:0] QPG_OFS_RES = 8'h04;
    localparam logic [7:0] QPG_OFS_POS = 8'h08;
    // Control register field positions.
    localparam int QPG_CTRL_CCW_BIT = 0;
    localparam int QPG_CTRL_LEN180_BIT = 1;
    // Resolution limits and reset value.
    localparam logic [16:0] QPG_RES_MIN = 17'h00001;
    localparam logic [16:0] QPG_RES_MAX_WIDE = 17'h10000;
    localparam logic [16:0] QPG_RES_MAX_NARROW = 17'h04000;
    localparam logic [16:0] QPG_RES_RST = 17'h00400;
    // Control reset value: clockwise, 90 degree index.
    localparam logic [1:0] QPG_CTRL_RST = 2'h0;
    // Non-volatile memory slot numbers.
    localparam logic [1:0] QPG_NVM_CTRL = 2'h0;
    localparam logic [1:0] QPG_NVM_RES = 2'h1;
    // Quadrature states per output pulse.
    localparam int QPG_STATES = 4;
endpackage

// *** rtl/qpg_top.sv ***
// Purpose: Scale shaft angle to programmed A/B/index pulses, APB setup.
// Assumes: angle_i and dir_i come from outside and are synchronised here.
// Notes: Every setting is pushed to non-volatile memory on each write.
`timescale 1ns/100ps
`default_nettype none
module qpg_top
    import qpg_pkg::*;
#(
    parameter bit NARROW_SERIES = 1'b0
)(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [15:0] angle_i,
    input wire logic dir_i,
    output logic chan_a_o,
    output logic chan_b_o,
    output logic index_o,
    output logic nvm_we_o,
    output logic [1:0] nvm_slot_o,
    output logic [16:0] nvm_data_o
);
    // Largest resolution allowed for the fitted series.
    localparam logic [16:0] RES_MAX =
        NARROW_SERIES ? QPG_RES_MAX_NARROW : QPG_RES_MAX_WIDE;

    logic [15:0] ang_s1_ff; // First synchroniser stage, read only by stage 2.
    logic [15:0] ang_ff; // Synchronised shaft angle.
    logic dir_s1_ff; // First synchroniser stage of the direction pin.
    logic dir_ff; // Synchronised direction pin.
    logic [1:0] ctrl_ff; // Direction and index width settings.
    logic [16:0] res_ff; // Pulses per revolution.
    logic [18:0] cnt_ff; // Quadrature state position, 0 to 4*res-1.
    logic [18:0] ofs_ff; // Angle-derived count that maps to position zero.
    logic [31:0] prdata_ff; // Read data captured in the setup phase.
    logic err_ff; // Unmapped address flag captured in the setup phase.
    logic a_ff, b_ff, idx_ff; // Registered pin drivers.
    logic up_ff; // Outputs not swapped by direction, for checking.
    logic nvm_we_ff;
    logic [1:0] nvm_slot_ff;
    logic [16:0] nvm_data_ff;

    logic setup, wr_acc, wr_res, wr_ctrl, mapped;
    logic [16:0] res_clamped;
    logic [18:0] modulus, target, track, fwd, ofs_new;
    logic [34:0] prod, prod_new;
    logic step_up, step_dn, inv;
    logic [1:0] ph;
    logic ph_a, ph_b, pulse0;

    // Bus decode; the slave never inserts wait states.
    assign setup = psel_i && !penable_i;
    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign mapped = paddr_i == QPG_OFS_CTRL || paddr_i == QPG_OFS_RES ||
                    paddr_i == QPG_OFS_POS;
    assign wr_res = wr_acc && paddr_i == QPG_OFS_RES;
    assign wr_ctrl = wr_acc && paddr_i == QPG_OFS_CTRL;
    assign pready_o = 1'b1;
    assign prdata_o = prdata_ff;
    assign pslverr_o = psel_i && penable_i && err_ff;

    // Both external inputs cross through two flops before any use.
    always_ff @(posedge mclk_i)
    begin
        ang_s1_ff <= angle_i;
        ang_ff <= ang_s1_ff;
        dir_s1_ff <= dir_i;
        dir_ff <= dir_s1_ff;
    end

    // Clamp instead of refusing, so a stray value still yields output.
    always_comb
    begin
        if (pwdata_i < 32'(QPG_RES_MIN))
            res_clamped = QPG_RES_MIN;
        else if (pwdata_i > 32'(RES_MAX))
            res_clamped = RES_MAX;
        else
            res_clamped = pwdata_i[16:0];
    end

    // Settings registers.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff <= QPG_CTRL_RST;
            res_ff <= QPG_RES_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_ff <= pwdata_i[1:0];
            if (wr_res)
                res_ff <= res_clamped;
        end
    end

    // Every CTRL or RES write is forwarded as one slot write, no commit step.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            nvm_we_ff <= 1'b0;
            nvm_slot_ff <= QPG_NVM_CTRL;
            nvm_data_ff <= 17'h00000;
        end
        else
        begin
            nvm_we_ff <= wr_res || wr_ctrl;
            if (wr_res)
            begin
                nvm_slot_ff <= QPG_NVM_RES;
                nvm_data_ff <= res_clamped;
            end
            else if (wr_ctrl)
            begin
                nvm_slot_ff <= QPG_NVM_CTRL;
                nvm_data_ff <= {15'h0000, pwdata_i[1:0]};
            end
        end
    end
    assign nvm_we_o = nvm_we_ff;
    assign nvm_slot_o = nvm_slot_ff;
    assign nvm_data_o = nvm_data_ff;

    // Scale angle to a state count, then move toward it one state a clock.
    always_comb
    begin
        modulus = {res_ff, 2'b00};
        prod = 35'(ang_ff) * 35'(modulus);
        target = prod[34:16];
        // The zero point must be in the scale of the incoming resolution.
        prod_new = 35'(ang_ff) * 35'({res_clamped, 2'b00});
        ofs_new = prod_new[34:16];
        if (target >= ofs_ff)
            track = target - ofs_ff;
        else
            track = 19'(target + modulus - ofs_ff);
        if (track >= cnt_ff)
            fwd = track - cnt_ff;
        else
            fwd = 19'(track + modulus - cnt_ff);
        // The shorter way round wins, so a wrap never runs backwards.
        step_up = fwd != 19'h00000 && fwd <= {1'b0, modulus[18:1]};
        step_dn = fwd != 19'h00000 && !step_up;
    end

    // Position counter; a new resolution restarts it at zero.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            cnt_ff <= 19'h00000;
            ofs_ff <= 19'h00000;
        end
        else if (wr_res)
        begin
            cnt_ff <= 19'h00000;
            ofs_ff <= ofs_new;
        end
        else if (step_up)
            cnt_ff <= cnt_ff == modulus - 19'h00001 ? 19'h00000 :
                      cnt_ff + 19'h00001;
        else if (step_dn)
            cnt_ff <= cnt_ff == 19'h00000 ? modulus - 19'h00001 :
                      cnt_ff - 19'h00001;
    end

    // Phase decode: 0 both low, 1 A, 2 both, 3 B, so A leads going up.
    always_comb
    begin
        ph = cnt_ff[1:0];
        ph_a = ph == 2'h1 || ph == 2'h2;
        ph_b = ph[1];
        pulse0 = cnt_ff[18:2] == 17'h00000;
        inv = ctrl_ff[QPG_CTRL_CCW_BIT] ^ dir_ff;
    end

    // Output flops; swapping A and B reverses the phase order.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            a_ff <= 1'b0;
            b_ff <= 1'b0;
            idx_ff <= 1'b0;
            up_ff <= 1'b0;
        end
        else
        begin
            a_ff <= inv ? ph_b : ph_a;
            b_ff <= inv ? ph_a : ph_b;
            up_ff <= !inv;
            if (ctrl_ff[QPG_CTRL_LEN180_BIT])
                idx_ff <= pulse0 && (inv ? ph_b : ph_a);
            else
                idx_ff <= pulse0 && ph == 2'h2;
        end
    end
    assign chan_a_o = a_ff;
    assign chan_b_o = b_ff;
    assign index_o = idx_ff;

    // Read data and error flag are prepared in the setup cycle.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            prdata_ff <= 32'h00000000;
            err_ff <= 1'b0;
        end
        else if (setup)
        begin
            err_ff <= !mapped;
            case (paddr_i)
                QPG_OFS_CTRL: prdata_ff <= {30'h00000000, ctrl_ff};
                QPG_OFS_RES: prdata_ff <= {15'h0000, res_ff};
                QPG_OFS_POS: prdata_ff <= {13'h0000, cnt_ff};
                default: prdata_ff <= 32'h00000000;
            endcase
        end
    end

    // A write access to the resolution register with a given value.
    sequence s_res_low;
        wr_res && pwdata_i == 32'h00000000;
    endsequence
    sequence s_res_high;
        wr_res && pwdata_i > 32'(RES_MAX);
    endsequence

    a_res_clamp_low: assert property (@(posedge mclk_i) disable iff (rst_i)
        s_res_low |=> res_ff == QPG_RES_MIN)
        else $error("low resolution not clamped");
    a_res_clamp_high: assert property (@(posedge mclk_i) disable iff (rst_i)
        s_res_high |=> res_ff == RES_MAX)
        else $error("high resolution not clamped");
    a_pos_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_res |=> cnt_ff == 19'h00000)
        else $error("position not cleared");
    a_pos_read: assert property (@(posedge mclk_i) disable iff (rst_i)
        setup && paddr_i == QPG_OFS_POS |=> prdata_o == {13'h0000,
        $past(cnt_ff)})
        else $error("position read wrong");
    a_nvm_store: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_res |=> nvm_we_o && nvm_slot_o == QPG_NVM_RES &&
        nvm_data_o == res_ff)
        else $error("resolution not stored");
    a_phase_order: assert property (@(posedge mclk_i) disable iff (rst_i)
        $rose(chan_a_o) && $past(up_ff) && up_ff && $past(step_up, 2)
        |-> !chan_b_o)
        else $error("A does not lead B");
    a_no_skip: assert property (@(posedge mclk_i) disable iff (rst_i)
        !$past(wr_res) && $past(res_ff) == res_ff |-> cnt_ff ==
        $past(cnt_ff) || cnt_ff == $past(cnt_ff) + 19'h00001 ||
        cnt_ff == $past(cnt_ff) - 19'h00001 || cnt_ff == 19'h00000 ||
        $past(cnt_ff) == 19'h00000)
        else $error("quadrature state skipped");
    a_idx_gate90: assert property (@(posedge mclk_i) disable iff (rst_i)
        index_o && !$past(ctrl_ff[QPG_CTRL_LEN180_BIT]) |->
        chan_a_o && chan_b_o)
        else $error("90 index not gated with A and B");
    a_idx_gate180: assert property (@(posedge mclk_i) disable iff (rst_i)
        index_o |-> chan_a_o)
        else $error("index not gated with A");
    a_dir_invert: assert property (@(posedge mclk_i) disable iff (rst_i)
        $past(inv) && $past(cnt_ff[1:0]) == 2'h1 |-> !chan_a_o &&
        chan_b_o)
        else $error("direction inversion wrong");
endmodule
`default_nettype wire

// *** tb/qpg_cnt_model.sv ***
// Purpose: Counter electronics that decode the A/B and index outputs.
// Assumes: The block drives registered levels, so sampling is safe.
// Notes: A two-phase jump cannot be decoded and is counted as a skip.
`timescale 1ns/100ps
`default_nettype none
module qpg_cnt_model (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic chan_a_i,
    input wire logic chan_b_i,
    input wire logic index_i,
    output int cnt_o,
    output int skip_o,
    output int idx_o
);
    logic [1:0] prv_ff; // Phase seen at the last edge.
    logic idx_ff; // Index level seen at the last edge.
    logic [1:0] ph; // Phase now: 0 is 00, 1 is A only, 2 both, 3 B only.
    logic [1:0] dlt; // Phase step since the last edge.
    assign ph = {chan_b_i, chan_a_i ^ chan_b_i};
    assign dlt = ph - prv_ff;
    // A leading B counts up, B leading A counts down, as a real counter.
    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            cnt_o <= 0;
            skip_o <= 0;
            idx_o <= 0;
        end
        else
        begin
            if (dlt == 2'h1)
                cnt_o <= cnt_o + 1;
            else if (dlt == 2'h3)
                cnt_o <= cnt_o - 1;
            else if (dlt == 2'h2)
                skip_o <= skip_o + 1;
            if (index_i && !idx_ff)
                idx_o <= idx_o + 1;
        end
        prv_ff <= ph;
        idx_ff <= index_i;
    end
endmodule
`default_nettype wire

// *** tb/tb_qpg_top.sv ***
// Purpose: Self-checking bench for the quadrature output block.
// Assumes: Zero wait state APB, wide series (maximum 65536 pulses).
// Notes: Direction is swapped only at phases 00 or 11, avoiding a jump.
`timescale 1ns/100ps
`default_nettype none
module tb_qpg_top;
    import qpg_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, dir = 1'b0, pready, pslverr, er;
    logic chan_a, chan_b, index, nvm_we;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] angle = 16'h0000;
    logic [1:0] nvm_slot, slot_q;
    logic [16:0] nvm_data, data_q;
    int cnt, skip, idx, nvm_n = 0, n0, bad_count = 0, check_count = 0;
    always #2.5 mclk = ~mclk;
    qpg_top qpg_top_i (.mclk_i(mclk), .rst_i(rst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .angle_i(angle), .dir_i(dir),
        .chan_a_o(chan_a), .chan_b_o(chan_b), .index_o(index),
        .nvm_we_o(nvm_we), .nvm_slot_o(nvm_slot), .nvm_data_o(nvm_data));
    qpg_cnt_model qpg_cnt_model_i (.mclk_i(mclk), .rst_i(rst),
        .chan_a_i(chan_a), .chan_b_i(chan_b), .index_i(index),
        .cnt_o(cnt), .skip_o(skip), .idx_o(idx));
    // Keep the last store request so a test can judge it afterwards.
    always @(posedge mclk)
    begin
        if (nvm_we === 1'b1)
        begin
            nvm_n <= nvm_n + 1;
            slot_q <= nvm_slot;
            data_q <= nvm_data;
        end
    end
    // Compare one value and count it.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the answer is taken at the edge with pready high.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Turn the shaft by n sixteenths of a turn, one state each at resolution 4, slowly enough for each one to settle.
    task rot(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            angle <= angle + 16'h1000;
            repeat (8) @(posedge mclk);
        end
    endtask
    // Write a setting and judge the store request that follows it.
    task wr_nvm(input logic [7:0] a, input logic [31:0] d,
                input logic [18:0] exp);
        n0 = nvm_n;
        apb(1'b1, a, d);
        repeat (3) @(posedge mclk);
        chk(nvm_n, n0 + 1);
        chk({slot_q, data_q}, exp);
    endtask
    // Reset values, and the refusal of an unmapped address.
    task t_reset();
        apb(1'b0, QPG_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, QPG_OFS_RES, 32'h0);
        chk(rd, 32'h400);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
    endtask
    // Turning with each direction choice, index and position read-back.
    task t_rot();
        wr_nvm(QPG_OFS_RES, 32'h4, {QPG_NVM_RES, 17'h00004});
        rot(2);
        apb(1'b0, QPG_OFS_POS, 32'h0);
        chk(rd, 32'h2);
        chk(cnt, 2);
        wr_nvm(QPG_OFS_CTRL, 32'h1, {QPG_NVM_CTRL, 17'h00001});
        rot(2);
        chk(cnt, 0);
        dir <= 1'b1;
        rot(2);
        chk(cnt, 2);
        dir <= 1'b0;
        wr_nvm(QPG_OFS_CTRL, 32'h0, {QPG_NVM_CTRL, 17'h00000});
        rot(11);
        chk(idx > 0, 1);
        chk(skip, 0);
        apb(1'b0, QPG_OFS_POS, 32'h0);
        chk(rd, 32'h1);
    endtask
    // Index 180 wide follows A alone and comes once per full turn.
    task t_idx();
        wr_nvm(QPG_OFS_CTRL, 32'h2, {QPG_NVM_CTRL, 17'h00002});
        chk({31'h0, index}, 32'h1);
        n0 = idx;
        rot(16);
        chk(idx, n0 + 1);
        chk(skip, 0);
        wr_nvm(QPG_OFS_CTRL, 32'h0, {QPG_NVM_CTRL, 17'h00000});
        chk({31'h0, index}, 32'h0);
        apb(1'b0, QPG_OFS_POS, 32'h0);
        chk(rd, 32'h1);
    endtask
    // Limits clamp, and every accepted value clears the position.
    task automatic t_res();
        logic [31:0] wv[4] = '{32'h0, 32'h20000, 32'h10000, 32'h5};
        logic [16:0] ev[4] = '{17'h00001, 17'h10000, 17'h10000, 17'h00005};
        for (int i = 0; i < 4; i++)
        begin
            wr_nvm(QPG_OFS_RES, wv[i], {QPG_NVM_RES, ev[i]});
            apb(1'b0, QPG_OFS_RES, 32'h0);
            chk(rd, {15'h0, ev[i]});
            apb(1'b0, QPG_OFS_POS, 32'h0);
            chk(rd, 32'h0);
        end
    endtask
    // Print the verdict and stop.
    task final_report();
        if (bad_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_rot();
        t_idx();
        t_res();
        final_report();
    end
    // The run needs under 3000 cycles; a hang is cut off well after.
    initial
    begin
        #60000;
        bad_count++;
        final_report();
    end
endmodule
`default_nettype wire
